/* File: rtl/tm_pkg.sv */
// Shared constants and carrier types of the temperature monitor core
package tm_pkg;
    // Timing
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned CONV_US = 31_250;
    localparam int unsigned CONV_CYC = CONV_US * (CLK_HZ / 1_000_000);
    localparam int unsigned TMO_MIN_MS = 25;
    localparam int unsigned TMO_CYC = TMO_MIN_MS * (CLK_HZ / 1_000);
    localparam int unsigned FAN_CLK_HZ = 90_000;
    localparam int unsigned FAN_DIV = CLK_HZ / FAN_CLK_HZ;
    localparam int unsigned PWM_HZ = 25_000;
    localparam int unsigned PWM_STEPS = 64;
    localparam int unsigned PWM_DIV = CLK_HZ / (PWM_HZ * PWM_STEPS);
    // Register indices; APB byte address is four times the index
    localparam logic [7:0] REG_LOCAL = 8'h00;
    localparam logic [7:0] REG_RT_HI = 8'h01;
    localparam logic [7:0] REG_RT_LO = 8'h02;
    localparam logic [7:0] REG_CFG = 8'h03;
    localparam logic [7:0] REG_RATE = 8'h04;
    localparam logic [7:0] REG_LHIGH = 8'h05;
    localparam logic [7:0] REG_RHIGH_HI = 8'h06;
    localparam logic [7:0] REG_RHIGH_LO = 8'h07;
    localparam logic [7:0] REG_RLOW_HI = 8'h08;
    localparam logic [7:0] REG_RLOW_LO = 8'h09;
    localparam logic [7:0] REG_RCRIT_HI = 8'h0A;
    localparam logic [7:0] REG_RCRIT_LO = 8'h0B;
    localparam logic [7:0] REG_HYST = 8'h0C;
    localparam logic [7:0] REG_OFFS_HI = 8'h0D;
    localparam logic [7:0] REG_OFFS_LO = 8'h0E;
    localparam logic [7:0] REG_STATUS = 8'h0F;
    localparam logic [7:0] REG_DUTY = 8'h10;
    localparam logic [7:0] REG_TACH_LO = 8'h11;
    localparam logic [7:0] REG_TACH_HI = 8'h12;
    // Configuration bits
    localparam int CFG_SMART = 0;
    localparam int CFG_TACH_SEL = 2;
    localparam int CFG_PWM_OFF_SB = 5;
    localparam int CFG_STANDBY = 6;
    localparam int CFG_ALERT_MASK = 7;
    // Alert status bits (busy is bit 7)
    localparam int ST_RCRIT = 0;
    localparam int ST_RLOW = 1;
    localparam int ST_RHIGH = 2;
    localparam int ST_LHIGH = 3;
    // Reset values
    localparam logic [7:0] RST_CFG = 8'h00;
    localparam logic [7:0] RST_RATE = 8'h00;
    localparam logic [7:0] RST_LHIGH = 8'h46;
    localparam logic [15:0] RST_RHIGH = 16'h4600;
    localparam logic [15:0] RST_RLOW = 16'h0000;
    localparam logic [15:0] RST_RCRIT = 16'h5500;
    localparam logic [7:0] RST_HYST = 8'h04;
    localparam logic [7:0] RST_DUTY = 8'h00;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] idx;
        logic [7:0] wdata;
    } tm_reg_req_t;

    typedef struct packed {
        logic [10:0] loc_code;
        logic [10:0] rem_code;
    } tm_adc_t;

    typedef enum logic [1:0] {
        CV_IDLE = 2'b00,
        CV_CONV = 2'b01,
        CV_WAIT = 2'b10
    } tm_conv_st_t;

    typedef enum logic [2:0] {
        SB_IDLE = 3'b000,
        SB_RX = 3'b001,
        SB_RACK = 3'b010,
        SB_TX = 3'b011,
        SB_TACK = 3'b100
    } tm_smb_st_t;
endpackage

/* File: rtl/tm_smb_target.sv */
// Two-wire serial target: byte engine, register pointer and bus timeout
`timescale 1ns/1ps
module tm_smb_target import tm_pkg::*; #(
    parameter logic [6:0] DEV_ADDR = 7'h2A,  // Arbitrary bus address
    parameter int unsigned TIMEOUT_CYCLES = TMO_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_oe_n,
    // Register access
    output tm_reg_req_t req,
    input wire logic [7:0] rdata
);
    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic scl_p;
        logic sda_p;
        tm_smb_st_t st;
        logic [7:0] sh;
        logic [3:0] cnt;
        logic adr;
        logic first;
        logic rw;
        logic nak;
        logic drv;
        logic [7:0] ptr;
        logic [19:0] tmo;
        tm_reg_req_t req;
    } tm_smb_state_t;

    tm_smb_state_t q, d;
    logic scl, sda, scl_r, scl_f, start, stop;

    assign scl = q.scl_s[1];
    assign sda = q.sda_s[1];
    assign scl_r = scl & ~q.scl_p;
    assign scl_f = ~scl & q.scl_p;
    assign start = scl & q.scl_p & q.sda_p & ~sda;
    assign stop = scl & q.scl_p & ~q.sda_p & sda;

    always_comb begin
        d = q;
        d.scl_s = {q.scl_s[0], scl_i};
        d.sda_s = {q.sda_s[0], sda_i};
        d.scl_p = scl;
        d.sda_p = sda;
        d.req.wr = 1'b0;
        d.req.rd = 1'b0;
        if (scl && sda) begin
            d.tmo = '0;
        end else if (q.tmo < 20'(TIMEOUT_CYCLES)) begin
            d.tmo = q.tmo + 20'h0_0001;
        end
        if (q.tmo >= 20'(TIMEOUT_CYCLES) || stop) begin
            d.st = SB_IDLE;
            d.drv = 1'b0;
        end else if (start) begin
            d.st = SB_RX;
            d.cnt = '0;
            d.adr = 1'b1;
            d.drv = 1'b0;
        end else begin
            case (q.st)
                SB_RX: begin
                    if (scl_r) begin
                        d.sh = {q.sh[6:0], sda};
                        d.cnt = q.cnt + 4'h1;
                    end else if (scl_f && q.cnt == 4'h8) begin
                        d.cnt = '0;
                        d.st = SB_RACK;
                        d.drv = 1'b1;
                        if (q.adr) begin
                            d.adr = 1'b0;
                            d.first = ~q.sh[0];
                            d.rw = q.sh[0];
                            if (q.sh[7:1] != DEV_ADDR) begin
                                d.st = SB_IDLE;
                                d.drv = 1'b0;
                            end
                        end else if (q.first) begin
                            d.ptr = q.sh;
                            d.first = 1'b0;
                        end else begin
                            d.req.wr = 1'b1;
                            d.req.wdata = q.sh;
                        end
                    end
                end
                SB_RACK: begin
                    if (scl_f && q.rw) begin
                        d.sh = rdata;
                        d.drv = ~rdata[7];
                        d.req.rd = 1'b1;
                        d.st = SB_TX;
                    end else if (scl_f) begin
                        d.drv = 1'b0;
                        d.st = SB_RX;
                    end
                end
                SB_TX: begin
                    if (scl_r) begin
                        d.cnt = q.cnt + 4'h1;
                    end else if (scl_f && q.cnt == 4'h8) begin
                        d.drv = 1'b0;
                        d.cnt = '0;
                        d.st = SB_TACK;
                    end else if (scl_f) begin
                        d.sh = {q.sh[6:0], 1'b0};
                        d.drv = ~q.sh[6];
                    end
                end
                SB_TACK: begin
                    if (scl_r) begin
                        d.nak = sda;
                    end else if (scl_f && q.nak) begin
                        d.st = SB_IDLE;
                    end else if (scl_f) begin
                        d.sh = rdata;
                        d.drv = ~rdata[7];
                        d.req.rd = 1'b1;
                        d.st = SB_TX;
                    end
                end
                default: d.st = SB_IDLE;
            endcase
        end
        d.req.idx = d.ptr;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '{scl_s: 2'b11, sda_s: 2'b11, scl_p: 1'b1, sda_p: 1'b1,
                   st: SB_IDLE, default: '0};
        end else begin
            q <= d;
        end
    end

    assign sda_oe_n = ~q.drv;
    assign req = q.req;
endmodule // tm_smb_target

/* File: rtl/tm_monitor.sv */
// Temperature monitor core: conversions, limits, alert, fan, APB registers
`timescale 1ns/1ps

module tm_monitor import tm_pkg::*; #(
    parameter int unsigned CONV_CYCLES = CONV_CYC,
    parameter int unsigned TIMEOUT_CYCLES = TMO_CYC,
    parameter logic [6:0] DEV_ADDR = 7'h2A  // Arbitrary bus address
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_oe_n,
    // Converter front end
    output logic adc_start,
    input wire tm_adc_t adc,
    // Shared alert / fan pulse pin
    input wire logic alert_tach_i,
    output logic alert_tach_oe_n,
    // Fan drive and power state
    output logic pwm_oe_n,
    output logic low_power
);
    typedef struct packed {
        logic [31:0] prdata;
        logic pslverr;
        logic [7:0] cfg;
        logic [7:0] rate;
        logic [7:0] lhigh;
        logic [15:0] rhigh;
        logic [15:0] rlow;
        logic [15:0] rcrit;
        logic [7:0] hyst;
        logic [15:0] offs;
        logic [7:0] duty;
        logic [7:0] lt;
        logic [15:0] rt;
        logic [3:0] status;
        logic [3:0] act;
        logic [15:0] tach;
        tm_conv_st_t cst;
        logic [19:0] ccnt;
        logic [3:0] wcnt;
        logic start;
        logic [1:0] t_s;
        logic t_p;
        logic [7:0] fdiv;
        logic [15:0] fcnt;
        logic [3:0] pdiv;
        logic [5:0] pcnt;
        logic pwm_on;
        logic alert;
    } tm_state_t;

    tm_state_t q, d;
    tm_reg_req_t smb_req;
    logic [7:0] smb_rdata;
    logic [7:0] apb_idx;
    logic apb_map, apb_wr, apb_rd;
    logic [8:0] apb_rd_val, smb_rd_val;
    logic [7:0] lt_new;
    logic [15:0] rt_new;
    logic signed [8:0] ltx, lhx, hl;
    logic signed [16:0] rtx, rhx, rlx, rcx, hr;
    logic [3:0] act_new;
    logic conv_end, wait_end, pwm_run, tick, step, tach_edge;

    ////////////////////////////////////////////////////////////////////////
    // Register access helpers

    function automatic logic [8:0] reg_read(tm_state_t s, logic [7:0] idx);
        logic [8:0] r;
        r = {1'b1, 8'h00};
        case (idx)
            REG_LOCAL: r[7:0] = s.lt;
            REG_RT_HI: r[7:0] = s.rt[15:8];
            REG_RT_LO: r[7:0] = s.rt[7:0];
            REG_CFG: r[7:0] = s.cfg;
            REG_RATE: r[7:0] = s.rate;
            REG_LHIGH: r[7:0] = s.lhigh;
            REG_RHIGH_HI: r[7:0] = s.rhigh[15:8];
            REG_RHIGH_LO: r[7:0] = s.rhigh[7:0];
            REG_RLOW_HI: r[7:0] = s.rlow[15:8];
            REG_RLOW_LO: r[7:0] = s.rlow[7:0];
            REG_RCRIT_HI: r[7:0] = s.rcrit[15:8];
            REG_RCRIT_LO: r[7:0] = s.rcrit[7:0];
            REG_HYST: r[7:0] = s.hyst;
            REG_OFFS_HI: r[7:0] = s.offs[15:8];
            REG_OFFS_LO: r[7:0] = s.offs[7:0];
            REG_STATUS: r[7:0] = {s.cst == CV_CONV, 3'b000, s.status};
            REG_DUTY: r[7:0] = s.duty;
            REG_TACH_LO: r[7:0] = s.tach[7:0];
            REG_TACH_HI: r[7:0] = s.tach[15:8];
            default: r = 9'h000;
        endcase
        return r;
    endfunction

    function automatic tm_state_t reg_write(tm_state_t s, logic [7:0] idx,
                                            logic [7:0] v);
        tm_state_t r;
        r = s;
        case (idx)
            REG_CFG: r.cfg = v;
            REG_RATE: r.rate = v;
            REG_LHIGH: r.lhigh = v;
            REG_RHIGH_HI: r.rhigh[15:8] = v;
            REG_RHIGH_LO: r.rhigh[7:0] = v;
            REG_RLOW_HI: r.rlow[15:8] = v;
            REG_RLOW_LO: r.rlow[7:0] = v;
            REG_RCRIT_HI: r.rcrit[15:8] = v;
            REG_RCRIT_LO: r.rcrit[7:0] = v;
            REG_HYST: r.hyst = v;
            REG_OFFS_HI: r.offs[15:8] = v;
            REG_OFFS_LO: r.offs[7:0] = v;
            REG_DUTY: r.duty = v;
            default: r = s;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Serial target

    tm_smb_target #(
        .DEV_ADDR(DEV_ADDR),
        .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
    ) u_smb (
        .pclk(pclk),
        .presetn(presetn),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .sda_oe_n(sda_oe_n),
        .req(smb_req),
        .rdata(smb_rdata)
    );

    assign smb_rd_val = reg_read(q, smb_req.idx);
    assign smb_rdata = smb_rd_val[7:0];

    ////////////////////////////////////////////////////////////////////////
    // Measurement formatting and limit comparison

    // Converter delivers sign plus ten magnitude bits, three fractional
    assign lt_new = adc.loc_code[10:3];
    // Offset wraps rather than saturates at the extremes of the range
    assign rt_new = {adc.rem_code, 5'h00} + q.offs;
    assign ltx = {lt_new[7], lt_new};
    assign lhx = {q.lhigh[7], q.lhigh};
    assign hl = {1'b0, q.hyst};
    assign rtx = {rt_new[15], rt_new};
    assign rhx = {q.rhigh[15], q.rhigh};
    assign rlx = {q.rlow[15], q.rlow};
    assign rcx = {q.rcrit[15], q.rcrit};
    assign hr = {1'b0, q.hyst, 8'h00};

    // A violation holds until the reading is back past the limit by hyst
    assign act_new[ST_LHIGH] = (ltx > lhx)
        | (q.act[ST_LHIGH] & (ltx > lhx - hl));
    assign act_new[ST_RHIGH] = (rtx > rhx)
        | (q.act[ST_RHIGH] & (rtx > rhx - hr));
    assign act_new[ST_RCRIT] = (rtx > rcx)
        | (q.act[ST_RCRIT] & (rtx > rcx - hr));
    assign act_new[ST_RLOW] = (rtx < rlx)
        | (q.act[ST_RLOW] & (rtx < rlx + hr));

    ////////////////////////////////////////////////////////////////////////
    // Strobes and APB decode

    assign conv_end = q.ccnt == 20'(CONV_CYCLES - 1);
    assign wait_end = conv_end && q.wcnt == 4'h1;
    assign tick = q.fdiv == 8'(FAN_DIV - 1);
    assign step = q.pdiv == 4'(PWM_DIV - 1);
    assign tach_edge = q.t_s[1] & ~q.t_p;
    assign pwm_run = ~(q.cfg[CFG_STANDBY] & q.cfg[CFG_PWM_OFF_SB]);
    assign apb_idx = paddr[9:2];
    assign apb_map = paddr[11:10] == 2'b00 && paddr[1:0] == 2'b00;
    assign apb_rd_val = reg_read(q, apb_idx);
    assign apb_wr = psel & penable & pwrite & apb_map;
    assign apb_rd = psel & penable & ~pwrite;

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        d = q;
        d.start = 1'b0;
        // Read data is captured in the setup phase for a zero-wait answer
        if (psel && !penable) begin
            d.prdata = {24'h00_0000, apb_rd_val[7:0]};
            d.pslverr = ~(apb_map & apb_rd_val[8]);
        end
        if (smb_req.wr) begin
            d = reg_write(d, smb_req.idx, smb_req.wdata);
        end
        if (apb_wr) begin
            d = reg_write(d, apb_idx, pwdata[7:0]);
        end
        if ((smb_req.rd && smb_req.idx == REG_STATUS)
                || (apb_rd && apb_map && apb_idx == REG_STATUS)) begin
            d.status = '0;
        end

        // Conversion sequencer
        case (q.cst)
            CV_IDLE: begin
                if (!q.cfg[CFG_STANDBY]) begin
                    d.cst = CV_CONV;
                    d.ccnt = '0;
                    d.start = 1'b1;
                end
            end
            CV_CONV: begin
                if (conv_end) begin
                    d.lt = lt_new;
                    d.rt = rt_new;
                    d.act = act_new;
                    d.status = d.status | act_new;
                    d.ccnt = '0;
                    d.wcnt = q.rate[3:0];
                    if (q.cfg[CFG_STANDBY]) begin
                        d.cst = CV_IDLE;
                    end else if (q.rate[3:0] == 4'h0) begin
                        d.start = 1'b1;
                    end else begin
                        d.cst = CV_WAIT;
                    end
                end else begin
                    d.ccnt = q.ccnt + 20'h0_0001;
                end
            end
            CV_WAIT: begin
                // Idle time is whole conversion periods, one per rate step
                if (q.cfg[CFG_STANDBY]) begin
                    d.cst = CV_IDLE;
                end else if (wait_end) begin
                    d.cst = CV_CONV;
                    d.ccnt = '0;
                    d.start = 1'b1;
                end else if (conv_end) begin
                    d.ccnt = '0;
                    d.wcnt = q.wcnt - 4'h1;
                end else begin
                    d.ccnt = q.ccnt + 20'h0_0001;
                end
            end
            default: d.cst = CV_IDLE;
        endcase

        // Fan pulse period, in fan counter ticks between rising edges
        d.t_s = {q.t_s[0], alert_tach_i};
        d.t_p = q.t_s[1];
        d.fdiv = tick ? 8'h00 : q.fdiv + 8'h01;
        if (tick && q.fcnt != 16'hFFFF) begin
            d.fcnt = q.fcnt + 16'h0001;
        end
        if (q.cfg[CFG_TACH_SEL] && tach_edge
                && (!q.cfg[CFG_SMART] || q.pwm_on)) begin
            d.tach = q.fcnt;
            d.fcnt = '0;
        end

        // Fan PWM: released (fan on) while the step count is below duty
        d.pdiv = step ? 4'h0 : q.pdiv + 4'h1;
        if (step) begin
            d.pcnt = q.pcnt + 6'h01;
        end
        d.pwm_on = pwm_run && ({2'b00, q.pcnt} < q.duty);

        // Alert only in alert mode and while unmasked
        d.alert = ~q.cfg[CFG_TACH_SEL] & ~q.cfg[CFG_ALERT_MASK]
            & (|q.status);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '{cfg: RST_CFG, rate: RST_RATE, lhigh: RST_LHIGH,
                   rhigh: RST_RHIGH, rlow: RST_RLOW, rcrit: RST_RCRIT,
                   hyst: RST_HYST, duty: RST_DUTY, cst: CV_IDLE,
                   default: '0};
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign prdata = q.prdata;
    assign pslverr = q.pslverr;
    assign pready = 1'b1;
    assign adc_start = q.start;
    assign alert_tach_oe_n = ~q.alert;
    assign pwm_oe_n = q.pwm_on;
    assign low_power = q.cst == CV_IDLE;
endmodule // tm_monitor

/* File: verification/tm_monitor_chk.sv */
// Checker of sequencing and pin properties of the monitor core
`timescale 1ns/1ps
module tm_monitor_chk import tm_pkg::*; #(
    parameter int unsigned CONV_CYCLES = 50,
    parameter int unsigned TIMEOUT_CYCLES = 200
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Watched pins
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_oe_n,
    input wire logic adc_start,
    input wire logic low_power
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    int unsigned gap_q;
    int unsigned low_q;
    ////////////////////////////////////////////////////////////////////////
    // Gap since last start; zero means no start seen since reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q <= 0;
            low_q <= 0;
        end else begin
            gap_q <= adc_start ? 1 : (gap_q == 0 ? 0 : gap_q + 1);
            low_q <= (scl_i && sda_i) ? 0 : low_q + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_quiet;
        !adc_start [*8];
    endsequence
    sequence s_wake;
        low_power || adc_start;
    endsequence
    a_start_pulse: assert property (adc_start |=> s_quiet)
        else $error("start pulse repeated too soon");
    a_conv_len: assert property (adc_start && gap_q != 0 |->
        gap_q >= CONV_CYCLES) else $error("conversion window too short");
    a_idle_start: assert property (low_power |-> !adc_start)
        else $error("conversion started in standby");
    a_wake_start: assert property (low_power |=> s_wake)
        else $error("left standby without a conversion");
    a_boot_start: assert property ($rose(presetn) |-> ##[1:3] adc_start)
        else $error("no conversion after reset");
    a_upper_zero: assert property (psel && penable |->
        prdata[31:8] == 24'h00_0000) else $error("read data upper bits set");
    a_pull_low: assert property ($fell(sda_oe_n) |-> !scl_i)
        else $error("data pulled while clock high");
    a_bus_timeout: assert property (low_q > TIMEOUT_CYCLES + 8 |->
        sda_oe_n) else $error("data held after bus timeout");
endmodule // tm_monitor_chk

bind tm_monitor tm_monitor_chk #(.CONV_CYCLES(CONV_CYCLES),
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .prdata(prdata), .scl_i(scl_i),
    .sda_i(sda_i), .sda_oe_n(sda_oe_n), .adc_start(adc_start),
    .low_power(low_power));

/* File: verification/tm_smb_host.sv */
// Two-wire bus host model; released lines read high by pull-up
`timescale 1ns/1ps
module tm_smb_host (
    // Bus levels
    output logic scl,
    output logic sda,
    input wire logic line
);
    // Clock stands high between frames
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // 400 ns bit; data moves only while the clock is low
    task automatic clk_bit(input logic b, output logic v);
        #50 sda = b;
        #200 scl = 1'b1;
        #75 v = line;
        #75 scl = 1'b0;
    endtask
    // Small skew keeps pin changes off the sampling clock edge
    task automatic start();
        #10;
        #50 sda = 1'b1;
        #200 scl = 1'b1;
        #100 sda = 1'b0;
        #200 scl = 1'b0;
    endtask
    task automatic stop();
        #10;
        #50 sda = 1'b0;
        #200 scl = 1'b1;
        #100 sda = 1'b1;
        #300;
    endtask
    // Eight bits MSB first plus the ninth acknowledge bit
    task automatic xfer(input logic [8:0] b, output logic [8:0] v);
        for (int i = 8; i >= 0; i--) begin
            clk_bit(b[i], v[i]);
        end
    endtask
endmodule // tm_smb_host

/* File: verification/temp_monitor_limit_compare_tb.sv */
// Self-checking bench of the temperature monitor core
`timescale 1ns/1ps
module temp_monitor_limit_compare_tb;
    import tm_pkg::*;
    localparam int CV = 50;
    localparam int TO = 200;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr;
    logic psel, penable, pwrite, pready, pslverr, er;
    logic [31:0] pwdata, prdata, rd;
    logic scl, sda_h, sda_oe_n, adc_start, al_n, pwm_oe_n, low_power;
    logic [8:0] r;
    logic tach = 1'b1;
    tm_adc_t adc;
    int n_fail = 0;
    int compares = 0;
    int p, s;
    logic [7:0] ri [6] = '{REG_LHIGH, REG_RHIGH_HI, REG_RCRIT_HI,
        REG_HYST, REG_CFG, REG_RLOW_HI};
    logic [7:0] ev [6] = '{8'h46, 8'h46, 8'h55, 8'h04, 8'h00, 8'h00};
    always #25 pclk = ~pclk;
    tm_monitor #(.CONV_CYCLES(CV), .TIMEOUT_CYCLES(TO)) uut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .scl_i(scl), .sda_i(sda_h & sda_oe_n), .sda_oe_n(sda_oe_n),
        .adc_start(adc_start), .adc(adc), .alert_tach_i(tach),
        .alert_tach_oe_n(al_n), .pwm_oe_n(pwm_oe_n), .low_power(low_power));
    tm_smb_host host (.scl(scl), .sda(sda_h), .line(sda_h & sda_oe_n));
    ////////////////////////////////////////////////////////////////////////
    task automatic cmp(input string n, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] i,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, i, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Two starts so one whole window ran on the current inputs
    task automatic conv();
        repeat (2) begin
            for (int k = 0; k < 4 * CV && adc_start !== 1'b1; k++)
                @(posedge pclk);
            @(posedge pclk);
        end
        repeat (3) @(posedge pclk);
    endtask
    task automatic watch();
        p = 0;
        s = 0;
        repeat (800) begin
            @(posedge pclk);
            p += (pwm_oe_n === 1'b1);
            s += (adc_start === 1'b1);
        end
    endtask
    task automatic end_of_test();
        if (n_fail == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        adc = {11'h190, 11'h191};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, ri[i], 0);
            cmp("reset value", ev[i], rd);
        end
        apb(1'b0, 8'h13, 0);
        cmp("unmapped", 1, er);
        apb(1'b1, REG_OFFS_HI, 1);
        conv();
        apb(1'b0, REG_LOCAL, 0);
        cmp("local", 8'h32, rd);
        apb(1'b0, REG_RT_HI, 0);
        cmp("remote hi", 8'h33, rd);
        apb(1'b0, REG_RT_LO, 0);
        cmp("remote lo", 8'h20, rd);
        adc <= {11'h258, 11'h2A8};
        conv();
        cmp("alert", 0, al_n);
        apb(1'b0, REG_STATUS, 0);
        cmp("status", 8'h0D, rd & 32'h0000_000F);
        // Still above limit minus hysteresis, so the flag returns
        adc <= {11'h220, 11'h191};
        conv();
        apb(1'b0, REG_STATUS, 0);
        cmp("hysteresis", 8'h08, rd & 32'h0000_000F);
        adc <= {11'h1E0, 11'h191};
        apb(1'b1, REG_RLOW_HI, 8'h40);
        apb(1'b0, REG_STATUS, 0);
        conv();
        cmp("alert low", 0, al_n);
        apb(1'b0, REG_STATUS, 0);
        cmp("low", 8'h02, rd & 32'h0000_000F);
        apb(1'b1, REG_CFG, 8'h80);
        conv();
        cmp("masked", 1, al_n);
        apb(1'b1, REG_DUTY, 32);
        apb(1'b1, REG_CFG, 8'hC0);
        repeat (2 * CV) @(posedge pclk);
        cmp("standby", 1, low_power);
        watch();
        cmp("pwm runs", 1, p != 0);
        cmp("no start", 0, s);
        apb(1'b1, REG_CFG, 8'hE0);
        watch();
        watch();
        cmp("pwm stops", 0, p);
        apb(1'b1, REG_CFG, 8'h80);
        watch();
        cmp("resume", 1, s != 0);
        host.start();
        host.xfer({7'h2A, 1'b0, 1'b1}, r);
        cmp("addr ack", 0, r[0]);
        host.xfer({REG_LHIGH, 1'b1}, r);
        host.xfer({8'h50, 1'b1}, r);
        host.stop();
        apb(1'b0, REG_LHIGH, 0);
        cmp("serial write", 8'h50, rd);
        // Stall mid-read while the target drives a zero
        host.start();
        host.xfer({7'h2A, 1'b1, 1'b1}, r);
        repeat (8) @(posedge pclk);
        cmp("drives", 0, sda_oe_n);
        repeat (TO + 20) @(posedge pclk);
        cmp("timeout", 1, sda_oe_n);
        host.stop();
        host.start();
        host.xfer({7'h2A, 1'b1, 1'b1}, r);
        host.xfer(9'h1FF, r);
        host.stop();
        cmp("serial read", 8'h50, r[8:1]);
        // Fan pulses every 2220 clocks, about ten counter ticks
        apb(1'b1, REG_CFG, 8'h04);
        repeat (3) begin
            tach <= 1'b0;
            repeat (1110) @(posedge pclk);
            tach <= 1'b1;
            repeat (1110) @(posedge pclk);
        end
        apb(1'b0, REG_TACH_LO, 0);
        cmp("tach", 1, rd >= 9 && rd <= 11);
        end_of_test();
    end
    // Run needs about 0.5 ms; four times that means a hang
    initial begin
        #2_000_000;
        n_fail++;
        end_of_test();
    end
endmodule // temp_monitor_limit_compare_tb
